/* rtl/port_cap_pkg.sv */
// Constants for the graphics port capability register group.
// Assumes the surrounding configuration header decodes dword addresses.
package port_cap_pkg;
  // ==========================================================
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0]  CAP_LIST_PTR_OFFSET = 8'h34;
  localparam logic [7:0]  CAP_HEADER_OFFSET   = 8'h44;
  localparam logic [7:0]  CAP_STATUS_OFFSET   = 8'h48;
  localparam logic [7:0]  CAP_COMMAND_OFFSET  = 8'h4C;
  // ==========================================================
  // Header fields
  localparam logic [7:0]  CAP_TYPE_CODE       = 8'h02;
  localparam logic [7:0]  FOLLOWING_ITEM      = 8'h00;
  localparam logic [3:0]  REV_MAJOR           = 4'h1;
  localparam logic [3:0]  REV_MINOR           = 4'h0;
  localparam int          REV_MAJOR_LSB       = 20;
  localparam int          REV_MINOR_LSB       = 16;
  localparam int          FOLLOWING_LSB       = 8;
  // ==========================================================
  // Status fields
  localparam logic [7:0]  MAX_REQUESTS        = 8'h04;
  localparam int          REQUESTS_LSB        = 24;
  localparam int          SIDEBAND_BIT        = 9;
  localparam logic [1:0]  RATE_SUPPORT        = 2'h1;
  // ==========================================================
  // Command fields and reset values
  localparam int          QUEUE_LIMIT_LSB     = 24;
  localparam int          MASTER_BIT          = 8;
  localparam logic [7:0]  QUEUE_LIMIT_RESET   = 8'h00;
  localparam logic        MASTER_RESET        = 1'b0;
  localparam logic [2:0]  RATE_RESET          = 3'h1;
  localparam logic [7:0]  CAP_LIST_PTR_VALUE  = 8'h44;
endpackage

/* rtl/port_cap_regs.sv */
// Graphics port capability registers: header, status and command words.
// Assumes single-cycle configuration reads and writes from the host bus
// interface, with byte enables, synchronous to clock.
//
// How it works
// - Header low byte reads type code 0x02.
// - Following-item pointer reads zero, last entry.
// - Major revision field reads 1.
// - Minor revision field reads 0.
// - Status top byte reads 4 requests.
// - Sideband support bit reads zero.
// - Supported rate field reads binary 01.
// - Sideband switch is read-only zero.
// - Master switch writable, reset clear, drives port_master_switch output and command read bit 8.
// - Rate field writable, resets to 1.
// - List pointer reads 0x44 when strapped, else zero.
`timescale 1ns/10ps
module port_cap_regs
  import port_cap_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Configuration access
  input  wire logic        cfg_read,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  // Strap and port controls
  input  wire logic        port_strap,
  output logic             port_master_switch,
  output logic      [2:0]  port_rate,
  output logic      [7:0]  request_queue_limit,
  output logic      [7:0]  capability_list_pointer
);

  // ==========================================================
  // Command word state
  logic [7:0] request_queue_limit_q, request_queue_limit_d;
  logic       port_master_switch_q, port_master_switch_d;
  logic [2:0] rate_q, rate_d;
  logic       strap_q, strap_d;
  logic [31:0] rdata_q, rdata_d;
  logic        cmd_hit;

  assign cmd_hit = cfg_write && (cfg_addr == CAP_COMMAND_OFFSET);

  // Only writable fields capture; reserved bits have no storage
  always_comb begin
    request_queue_limit_d = request_queue_limit_q;
    port_master_switch_d  = port_master_switch_q;
    rate_d                = rate_q;
    strap_d               = port_strap; // strap caught by clock, not by reset
    if (cmd_hit && cfg_byte_en[3]) begin
      request_queue_limit_d = cfg_wdata[QUEUE_LIMIT_LSB +: 8];
    end
    if (cmd_hit && cfg_byte_en[1]) begin
      port_master_switch_d = cfg_wdata[MASTER_BIT];
    end
    if (cmd_hit && cfg_byte_en[0]) begin
      rate_d = cfg_wdata[2:0];
    end
  end

  // Read multiplexer; unmapped offsets return zero
  always_comb begin
    rdata_d = rdata_q;
    if (cfg_read) begin
      if (cfg_addr == CAP_HEADER_OFFSET) begin
        rdata_d = {8'h00,
                   REV_MAJOR,
                   REV_MINOR,
                   FOLLOWING_ITEM,
                   CAP_TYPE_CODE};
      end else if (cfg_addr == CAP_STATUS_OFFSET) begin
        rdata_d = {MAX_REQUESTS,
                   14'h0000,
                   1'b0,
                   7'h00,
                   RATE_SUPPORT};
      end else if (cfg_addr == CAP_COMMAND_OFFSET) begin
        rdata_d = {request_queue_limit_q, 14'h0000,
                   1'b0,
                   port_master_switch_q, 5'h00, rate_q};
      end else if (cfg_addr == CAP_LIST_PTR_OFFSET) begin
        rdata_d = {24'h000000, capability_list_pointer};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // Registers; reset only loads constants
  always_ff @(posedge clock) begin
    if (!nrst) begin
      request_queue_limit_q <= QUEUE_LIMIT_RESET;
      port_master_switch_q  <= MASTER_RESET;
      rate_q                <= RATE_RESET;
      strap_q               <= 1'b0;
      rdata_q               <= 32'h00000000;
    end else begin
      request_queue_limit_q <= request_queue_limit_d;
      port_master_switch_q  <= port_master_switch_d;
      rate_q                <= rate_d;
      strap_q               <= strap_d;
      rdata_q               <= rdata_d;
    end
  end

  // Outputs from flip-flops
  assign cfg_rdata               = rdata_q;
  assign port_master_switch      = port_master_switch_q;
  assign port_rate               = rate_q;
  assign request_queue_limit     = request_queue_limit_q;
  assign capability_list_pointer = strap_q ? CAP_LIST_PTR_VALUE : 8'h00;

  // ==========================================================
  // Checks
  // Antecedents other than the constant-bit and reset checks sample nrst, so the releasing edge is never taken as an access
  property p_master_write;
    @(posedge clock) disable iff (!nrst)
      nrst && cmd_hit && cfg_byte_en[1] |=> port_master_switch == $past(cfg_wdata[MASTER_BIT]);
  endproperty
  a_master_write: assert property (p_master_write) else $error("master switch missed write");

  property p_rate_write;
    @(posedge clock) disable iff (!nrst)
      nrst && cmd_hit && cfg_byte_en[0] |=> port_rate == $past(cfg_wdata[2:0]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate missed write");

  property p_rate_hold;
    @(posedge clock) disable iff (!nrst)
      nrst && !(cmd_hit && cfg_byte_en[0]) |=> $stable(port_rate);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed without write");

  property p_header;
    @(posedge clock) disable iff (!nrst)
      cfg_read && cfg_addr == CAP_HEADER_OFFSET |=> cfg_rdata == 32'h00100002;
  endproperty
  a_header: assert property (p_header) else $error("header word wrong");

  property p_status;
    @(posedge clock) disable iff (!nrst)
      cfg_read && cfg_addr == CAP_STATUS_OFFSET |=> cfg_rdata == 32'h04000001;
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");

  property p_cmd_reserved;
    @(posedge clock) disable iff (!nrst)
      cfg_read && cfg_addr == CAP_COMMAND_OFFSET |=> (cfg_rdata & 32'h00FFFEF8) == 32'h00000000;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved) else $error("command reserved bits set");

  property p_sideband_off;
    @(posedge clock) disable iff (!nrst)
      cfg_read && cfg_addr == CAP_COMMAND_OFFSET |=> !cfg_rdata[SIDEBAND_BIT];
  endproperty
  a_sideband_off: assert property (p_sideband_off) else $error("sideband switch reads one");

  property p_list_ptr;
    @(posedge clock) disable iff (!nrst)
      nrst && port_strap |=> capability_list_pointer == CAP_LIST_PTR_VALUE;
  endproperty
  a_list_ptr: assert property (p_list_ptr) else $error("list pointer wrong when strapped");

  property p_list_ptr_off;
    @(posedge clock) disable iff (!nrst)
      nrst && !port_strap |=> capability_list_pointer == 8'h00;
  endproperty
  a_list_ptr_off: assert property (p_list_ptr_off) else $error("list pointer set without strap");

  property p_master_hold;
    @(posedge clock) disable iff (!nrst)
      nrst && !(cmd_hit && cfg_byte_en[1]) |=> $stable(port_master_switch);
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("master switch changed without write");

  property p_queue_write;
    @(posedge clock) disable iff (!nrst)
      nrst && cmd_hit && cfg_byte_en[3] |=> request_queue_limit == $past(cfg_wdata[QUEUE_LIMIT_LSB +: 8]);
  endproperty
  a_queue_write: assert property (p_queue_write) else $error("queue limit missed write");

  property p_queue_hold;
    @(posedge clock) disable iff (!nrst)
      nrst && !(cmd_hit && cfg_byte_en[3]) |=> $stable(request_queue_limit);
  endproperty
  a_queue_hold: assert property (p_queue_hold) else $error("queue limit changed without write");

  // Reset seen at one edge leaves every register at its reset value at the next
  property p_reset_state;
    @(posedge clock)
      !nrst |=> port_master_switch == MASTER_RESET && port_rate == RATE_RESET &&
                request_queue_limit == QUEUE_LIMIT_RESET && cfg_rdata == 32'h00000000 &&
                capability_list_pointer == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("register not at reset value");

  property p_list_read;
    @(posedge clock) disable iff (!nrst)
      nrst && cfg_read && cfg_addr == CAP_LIST_PTR_OFFSET |=>
        cfg_rdata == {24'h000000, $past(capability_list_pointer)};
  endproperty
  a_list_read: assert property (p_list_read) else $error("list pointer read wrong");

  property p_cmd_read;
    @(posedge clock) disable iff (!nrst)
      nrst && cfg_read && cfg_addr == CAP_COMMAND_OFFSET |=>
        cfg_rdata[QUEUE_LIMIT_LSB +: 8] == $past(request_queue_limit) &&
        cfg_rdata[MASTER_BIT] == $past(port_master_switch) && cfg_rdata[2:0] == $past(port_rate);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read does not match fields");

  property p_unmapped_read;
    @(posedge clock) disable iff (!nrst)
      nrst && cfg_read && cfg_addr != CAP_HEADER_OFFSET && cfg_addr != CAP_STATUS_OFFSET &&
        cfg_addr != CAP_COMMAND_OFFSET && cfg_addr != CAP_LIST_PTR_OFFSET |=> cfg_rdata == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_status_sideband;
    @(posedge clock) disable iff (!nrst)
      cfg_read && cfg_addr == CAP_STATUS_OFFSET |=> !cfg_rdata[SIDEBAND_BIT];
  endproperty
  a_status_sideband: assert property (p_status_sideband) else $error("sideband support reads one");

endmodule

/* verif/port_target_model.sv */
// Far-side target model: reports its own request depth.
// Assumes the bench sets its rate before asking it to enable.
`timescale 1ns/10ps
module port_target_model #(
  parameter logic [7:0] DEPTH = 8'h02
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Software controls
  input  wire logic [2:0] set_rate,
  input  wire logic       set_enable,
  output logic      [7:0] target_depth,
  output logic            target_on
);
  // ==========================================================
  // Depth that software copies into the device
  assign target_depth = DEPTH;
  // Enable refused unless single rate is already set
  always_ff @(posedge clock) begin
    if (!nrst)
      target_on <= 1'b0;
    else if (set_enable && set_rate == 3'h1)
      target_on <= 1'b1;
  end
endmodule

/* verif/tb.sv */
// Testbench for the capability registers: configuration reads and
// writes against expected words. Assumes one-cycle read latency.
`timescale 1ns/10ps
module tb;
  import port_cap_pkg::*;
  // ==========================================================
  // Signals
  logic        clock, nrst, cfg_read, cfg_write, port_strap, set_enable;
  logic [7:0]  cfg_addr, request_queue_limit, capability_list_pointer, target_depth;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0]  port_rate, set_rate;
  logic        port_master_switch, target_on;
  int          mismatches, n_checks;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  port_cap_regs port_cap_regs_inst (.clock(clock), .nrst(nrst), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .port_strap(port_strap), .port_master_switch(port_master_switch),
    .port_rate(port_rate), .request_queue_limit(request_queue_limit),
    .capability_list_pointer(capability_list_pointer));
  port_target_model port_target_model_inst (.clock(clock), .nrst(nrst), .set_rate(set_rate),
    .set_enable(set_enable), .target_depth(target_depth), .target_on(target_on));
  // ==========================================================
  // Access tasks: one idle cycle between requests keeps drives apart
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfg_write   <= 1'b1;
    cfg_addr    <= a;
    cfg_byte_en <= be;
    cfg_wdata   <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1;
    `CHK(cfg_rdata, e)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Main sequence
  initial begin
    {nrst, cfg_read, cfg_write, set_enable} = 4'h0;
    {cfg_addr, cfg_byte_en, cfg_wdata, set_rate} = '0;
    port_strap = 1'b1;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    rd(8'h34, 32'h00000044);
    `CHK(capability_list_pointer, 8'h44)
    rd(8'h44, 32'h00100002);
    rd(8'h48, 32'h04000001);
    rd(8'h4C, 32'h00000001);
    wr(8'h4C, 4'hF, 32'hFFFFFFFF);
    rd(8'h4C, 32'hFF000107);
    `CHK(port_rate, 3'h7)
    wr(8'h4C, 4'h2, 32'h00000000);
    rd(8'h4C, 32'hFF000007);
    wr(8'h44, 4'hF, 32'hFFFFFFFF);
    wr(8'h48, 4'hF, 32'hFFFFFFFF);
    rd(8'h44, 32'h00100002);
    rd(8'h48, 32'h04000001);
    rd(8'h50, 32'h00000000);
    // Bring-up order: target rate, target enable, then device master
    @(posedge clock);
    set_rate <= 3'h1;
    @(posedge clock);
    set_enable <= 1'b1;
    @(posedge clock);
    #1;
    `CHK(target_on, 1'b1)
    wr(8'h4C, 4'hF, {target_depth, 24'h000101});
    rd(8'h4C, 32'h02000101);
    `CHK(port_master_switch, 1'b1)
    `CHK(request_queue_limit, 8'h02)
    @(posedge clock);
    port_strap <= 1'b0;
    rd(8'h34, 32'h00000000);
    `CHK(capability_list_pointer, 8'h00)
    // Reset in mid-run returns the command word to reset values, rate 1
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    #1;
    `CHK({port_master_switch, port_rate, request_queue_limit}, 12'h100)
    `CHK(cfg_rdata, 32'h00000000)
    rd(8'h4C, 32'h00000001);
    final_report();
  end
endmodule
